//--- imcd_decoder.v
// Incremental move command decoder with AHB-Lite register slave
// Behaviour
// - Enable held asserted energizes motor; deasserting de-energizes it.
// - Four-increment mode: short enable drop is a move trigger, not a disable.
// - Four-increment mode: line_a and line_b pick one of four increments.
// - Trigger modes launch exactly one increment per trigger and none without one.
// - Triggers during accel or cruise merge into one move; controller sends them fast.
// - Four-increment mode: trigger during deceleration launches a separate move.
// - Home-to-switch two-increment: decel trigger waits for stop, then executes.
// - Hard-stop two-increment mode: line_b level selects the active increment.
// - Hard-stop two and single modes launch on chosen line_a edge.
// - Line_a modes: short enable pulse makes next move use alternate speed.
// - Repeated line_a cycles before decel join into count times increment.
// - Each move target is current position plus increment.
// - Positive increment turns counter-clockwise, negative clockwise.
// - Single-increment mode moves only in the sign of its one increment.
// - Home-to-switch two-increment: line_a selects increment, line_b is home switch.
// - Home switch polarity can be inverted.
// - Auto homing on first enable only or on every enable.
// - Hard-stop two-increment mode optionally homes to hard stop before moves.
// - Pulse-burst: each line_b pulse moves one distance unit.
// - Pulse-burst: two speeds and one acceleration rate only.
// - Pulse-burst: line_a level gives direction.
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`include "imcd_map.vh"
`default_nettype none
module imcd_decoder (
  input wire ref_clk,
  input wire arst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire enableIn,
  input wire lineA,
  input wire lineB,
  input wire [1:0] motionPhase,
  input wire homeDone,
  output reg motorOn,
  output reg moveStrobe,
  output reg [31:0] moveTarget,
  output reg moveDirCw,
  output reg moveAltSpeed,
  output reg moveChain,
  output reg homeStart,
  output reg homeToSwitch,
  output reg homeSwitchHit
);

  // ****************************************************************
  // Register slave
  // ****************************************************************
  reg [31:0] ctrl_q;
  reg [31:0] pulseW_q;
  reg [31:0] inc0_q;
  reg [31:0] inc1_q;
  reg [31:0] inc2_q;
  reg [31:0] inc3_q;
  reg [31:0] unit_q;
  reg [31:0] pos_q;
  reg [7:0] addrQ_q;
  reg wrPend_q;
  reg homed_q;
  reg homing_q;
  reg pending_q;
  reg altNext_q;

  wire [2:0] mode = ctrl_q[`IMCD_CTRL_MODE_LSB +: 3];
  wire risingSel = ctrl_q[`IMCD_CTRL_EDGE_BIT];
  wire homeInv = ctrl_q[`IMCD_CTRL_HINV_BIT];
  wire homeOn = ctrl_q[`IMCD_CTRL_HOMEON_BIT];
  wire homeAll = ctrl_q[`IMCD_CTRL_HOMEALL_BIT];
  wire addrPhase = hsel & hready & htrans[1];

  // Read mux; unmapped addresses read zero
  function [31:0] regRead;
    input [7:0] a;
    begin
      case (a)
        `IMCD_OFF_CTRL: regRead = ctrl_q;
        `IMCD_OFF_PULSEW: regRead = pulseW_q;
        `IMCD_OFF_INC0: regRead = inc0_q;
        `IMCD_OFF_INC1: regRead = inc1_q;
        `IMCD_OFF_INC2: regRead = inc2_q;
        `IMCD_OFF_INC3: regRead = inc3_q;
        `IMCD_OFF_UNIT: regRead = unit_q;
        `IMCD_OFF_STATUS: regRead = {26'h0, altNext_q, pending_q, homing_q, homed_q,
          motionPhase == `IMCD_PH_DEC, motorOn};
        `IMCD_OFF_POS: regRead = pos_q;
        `IMCD_OFF_MOVE: regRead = moveTarget;
        default: regRead = 32'h0;
      endcase
    end
  endfunction

  // Zero-wait-state slave: address taken, data phase one cycle later
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addrQ_q <= 8'h0;
      wrPend_q <= 1'b0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wrPend_q <= addrPhase & hwrite;
      if (addrPhase)
        addrQ_q <= haddr[7:0];
      if (addrPhase & ~hwrite)
        hrdata <= regRead(haddr[7:0]);
    end
  end

  // Register writes land in the data phase
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= 32'h0;
      pulseW_q <= `IMCD_PULSEW_RST;
      inc0_q <= 32'h0;
      inc1_q <= 32'h0;
      inc2_q <= 32'h0;
      inc3_q <= 32'h0;
      unit_q <= 32'h1;
    end
    else if (wrPend_q)
    begin
      case (addrQ_q)
        `IMCD_OFF_CTRL: ctrl_q <= hwdata;
        `IMCD_OFF_PULSEW: pulseW_q <= hwdata;
        `IMCD_OFF_INC0: inc0_q <= hwdata;
        `IMCD_OFF_INC1: inc1_q <= hwdata;
        `IMCD_OFF_INC2: inc2_q <= hwdata;
        `IMCD_OFF_INC3: inc3_q <= hwdata;
        `IMCD_OFF_UNIT: unit_q <= hwdata;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ****************************************************************
  // Input synchronisers and edge detectors
  // ****************************************************************
  reg [2:0] enSync_q;
  reg [2:0] aSync_q;
  reg [2:0] bSync_q;

  // Stage 0 feeds only stage 1; edges compare stages 1 and 2
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enSync_q <= 3'h0;
      aSync_q <= 3'h0;
      bSync_q <= 3'h0;
    end
    else
    begin
      enSync_q <= {enSync_q[1:0], enableIn};
      aSync_q <= {aSync_q[1:0], lineA};
      bSync_q <= {bSync_q[1:0], lineB};
    end
  end

  wire enLvl = enSync_q[1];
  wire enRise = enSync_q[1] & ~enSync_q[2];
  wire aLvl = aSync_q[1];
  wire aRise = aSync_q[1] & ~aSync_q[2];
  wire aFall = ~aSync_q[1] & aSync_q[2];
  wire bLvl = bSync_q[1];
  wire bRise = bSync_q[1] & ~bSync_q[2];
  wire aLaunch = risingSel ? aRise : aFall;

  // ****************************************************************
  // Enable pulse classifier
  // ****************************************************************
  reg [31:0] lowCnt_q;
  reg disabled_q;
  wire longLow = lowCnt_q >= pulseW_q;
  // A short drop ends before the limit: pulse; reaching it means disable
  wire enPulse = enRise & ~disabled_q;

  // The motor stays on through a short drop, so only the disable decision
  // cuts power; this costs pulseW cycles of delay before de-energizing.
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowCnt_q <= 32'h0;
      disabled_q <= 1'b1;
    end
    else if (enLvl)
    begin
      lowCnt_q <= 32'h0;
      disabled_q <= 1'b0;
    end
    else
    begin
      if (!longLow)
        lowCnt_q <= lowCnt_q + 32'h1;
      else
        disabled_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Homing
  // ****************************************************************
  wire homeLvl = bLvl ^ homeInv;
  wire swMode = (mode == `IMCD_MODE_TWO_SW) | (mode == `IMCD_MODE_ONE);
  // The remaining modes home against a hard stop when homing is on
  wire enableEvt = enRise & disabled_q;

  // Homing on the enable that ends a disable; first-only or every time
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      homed_q <= 1'b0;
      homing_q <= 1'b0;
      homeStart <= 1'b0;
      homeToSwitch <= 1'b0;
      homeSwitchHit <= 1'b0;
    end
    else
    begin
      homeStart <= 1'b0;
      homeSwitchHit <= swMode & homeLvl;
      if (enableEvt & homeOn & (homeAll | ~homed_q))
      begin
        homing_q <= 1'b1;
        homeStart <= 1'b1;
        homeToSwitch <= swMode;
      end
      else if (homing_q & (homeDone | disabled_q))
      begin
        homing_q <= 1'b0;
        homed_q <= homeDone;
      end
    end
  end

  // ****************************************************************
  // Move launch
  // ****************************************************************
  // Increment selection per mode
  reg [31:0] incSel;
  always @*
  begin
    case (mode)
      `IMCD_MODE_FOUR:
        case ({aLvl, bLvl})
          2'h0: incSel = inc0_q;
          2'h1: incSel = inc1_q;
          2'h2: incSel = inc2_q;
          default: incSel = inc3_q;
        endcase
      `IMCD_MODE_TWO_HS: incSel = bLvl ? inc1_q : inc0_q;
      `IMCD_MODE_TWO_SW: incSel = aLvl ? inc1_q : inc0_q;
      `IMCD_MODE_ONE: incSel = inc0_q;
      `IMCD_MODE_BURST: incSel = aLvl ? (32'h0 - unit_q) : unit_q;
      default: incSel = 32'h0;
    endcase
  end

  // Launch sources: enable trigger, line_a edge, or burst pulse
  wire trigMode = (mode == `IMCD_MODE_FOUR) | (mode == `IMCD_MODE_TWO_SW);
  wire edgeMode = (mode == `IMCD_MODE_TWO_HS) | (mode == `IMCD_MODE_ONE);
  wire burstMode = mode == `IMCD_MODE_BURST;
  wire ready = motorOn & ~homing_q;
  wire launch = ready & ((trigMode & enPulse) | (edgeMode & aLaunch) |
    (burstMode & bRise));
  wire inDecel = motionPhase == `IMCD_PH_DEC;
  wire moving = motionPhase != `IMCD_PH_IDLE;
  // Home-to-switch two mode waits out a decelerating move
  wire holdOff = (mode == `IMCD_MODE_TWO_SW) & inDecel;

  // Function for the common target sum, relative to current position
  function [31:0] addInc;
    input [31:0] base;
    input [31:0] inc;
    begin
      addInc = base + inc;
    end
  endfunction

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      motorOn <= 1'b0;
      moveStrobe <= 1'b0;
      moveTarget <= 32'h0;
      moveDirCw <= 1'b0;
      moveAltSpeed <= 1'b0;
      moveChain <= 1'b0;
      pos_q <= 32'h0;
      pending_q <= 1'b0;
      altNext_q <= 1'b0;
    end
    else
    begin
      motorOn <= ~disabled_q;
      moveStrobe <= 1'b0;
      if ((edgeMode | burstMode) & enPulse)
        altNext_q <= 1'b1;
      if (launch & holdOff)
        pending_q <= 1'b1;
      else if ((launch | (pending_q & ~moving)) & ready)
      begin
        pending_q <= pending_q & launch;
        moveStrobe <= 1'b1;
        // Chained target builds on last target, so N cycles give N increments
        moveChain <= moving & ~inDecel;
        moveTarget <= addInc((moving & ~inDecel) ? moveTarget : pos_q, incSel);
        pos_q <= addInc((moving & ~inDecel) ? moveTarget : pos_q, incSel);
        moveDirCw <= incSel[31];
        // Burst mode only offers normal and alternate speed
        moveAltSpeed <= altNext_q & ~trigMode;
        if (!((edgeMode | burstMode) & enPulse))
          altNext_q <= 1'b0;
      end
      if (disabled_q)
        pending_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- imcd_decoder_properties.sv
// Port checker for the incremental move command decoder
`default_nettype none
// ****
// Checker
// ****
module imcd_props (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic enableIn,
  input wire logic lineA,
  input wire logic lineB,
  input wire logic [1:0] motionPhase,
  input wire logic motorOn,
  input wire logic moveStrobe,
  input wire logic [31:0] moveTarget
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] prevQ;
  logic [3:0] quietQ;
  // Cycles since a command or phase input moved; a strobe needs a recent cause
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      prevQ <= 5'h0;
      quietQ <= 4'hf;
    end
    else
    begin
      prevQ <= {enableIn, lineA, lineB, motionPhase};
      quietQ <= ({enableIn, lineA, lineB, motionPhase} != prevQ) ? 4'h0 :
        (quietQ == 4'hf) ? 4'hf : quietQ + 4'h1;
    end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // Short drop; assumes the bench keeps the pulse width above four cycles
  sequence s_drop;
    enableIn ##1 !enableIn [*3];
  endsequence
  property p_ready;
    hreadyout;
  endproperty
  property p_resp;
    !hresp;
  endproperty
  property p_pulse;
    moveStrobe |=> !moveStrobe;
  endproperty
  property p_hold;
    !moveStrobe |-> $stable(moveTarget);
  endproperty
  property p_cause;
    moveStrobe |-> quietQ <= 4'ha && motorOn;
  endproperty
  property p_on;
    $rose(motorOn) |-> $past(enableIn, 3);
  endproperty
  property p_off;
    $fell(motorOn) |-> !$past(enableIn, 3) && !$past(enableIn, 4);
  endproperty
  property p_keep;
    motorOn ##0 s_drop |=> motorOn;
  endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  a_resp: assert property (p_resp) else $error("response not OKAY");
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  a_hold: assert property (p_hold) else $error("target moved");
  a_cause: assert property (p_cause) else $error("move without cause");
  a_on: assert property (p_on) else $error("motor on early");
  a_off: assert property (p_off) else $error("motor off early");
  a_keep: assert property (p_keep) else $error("pulse disabled");
endmodule
bind imcd_decoder imcd_props i_imcd_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .hreadyout(hreadyout), .hresp(hresp),
  .enableIn(enableIn), .lineA(lineA), .lineB(lineB), .motionPhase(motionPhase),
  .motorOn(motorOn), .moveStrobe(moveStrobe), .moveTarget(moveTarget));
`default_nettype wire

//--- imcd_map.vh
// Constants for the incremental move command decoder
`ifndef IMCD_MAP_VH
`define IMCD_MAP_VH
// Mode codes
`define IMCD_MODE_FOUR 3'h0
`define IMCD_MODE_TWO_HS 3'h1
`define IMCD_MODE_TWO_SW 3'h2
`define IMCD_MODE_ONE 3'h3
`define IMCD_MODE_BURST 3'h4
// Register byte offsets
`define IMCD_OFF_CTRL 8'h00
`define IMCD_OFF_PULSEW 8'h04
`define IMCD_OFF_INC0 8'h08
`define IMCD_OFF_INC1 8'h0c
`define IMCD_OFF_INC2 8'h10
`define IMCD_OFF_INC3 8'h14
`define IMCD_OFF_UNIT 8'h18
`define IMCD_OFF_STATUS 8'h1c
`define IMCD_OFF_POS 8'h20
`define IMCD_OFF_MOVE 8'h24
// Control field positions
`define IMCD_CTRL_MODE_LSB 0
`define IMCD_CTRL_EDGE_BIT 4
`define IMCD_CTRL_HINV_BIT 5
`define IMCD_CTRL_HOMEON_BIT 6
`define IMCD_CTRL_HOMEALL_BIT 7
`define IMCD_CTRL_PHASE_LSB 8
// Reset values
`define IMCD_PULSEW_RST 32'h000003e8
`define IMCD_HOME_HOLD 16'h0064
// Motion phase codes reported by the trajectory generator
`define IMCD_PH_IDLE 2'h0
`define IMCD_PH_ACC 2'h1
`define IMCD_PH_CRUISE 2'h2
`define IMCD_PH_DEC 2'h3
`endif

//--- imcd_plc.sv
// Controller model driving the enable and command lines
`default_nettype none
// ****
// Controller
// ****
module imcd_plc (
  input wire logic ref_clk,
  output var logic enableIn,
  output var logic lineA,
  output var logic lineB
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines start low, motor off
  initial
  begin
    enableIn = 1'b0;
    lineA = 1'b0;
    lineB = 1'b0;
  end
  // Drop enable for n cycles: short is a pulse, long a disable
  task automatic dropEnable(input int n);
    @(posedge ref_clk);
    enableIn <= 1'b0;
    repeat (n) @(posedge ref_clk);
    enableIn <= 1'b1;
  endtask
  // Burst of n line_b pulses, line_a giving the sign; one pulse every two cycles
  // keeps the burst well ahead of any speed limit
  task automatic burst(input logic a, input int n);
    for (int k = 0; k < n; k++)
    begin
      setLines(a, 1'b1);
      setLines(a, 1'b0);
    end
  endtask
  // Both lines change together so one edge carries the whole choice
  task automatic setLines(input logic a, input logic b);
    @(posedge ref_clk);
    lineA <= a;
    lineB <= b;
  endtask
endmodule
`default_nettype wire

//--- test_incremental_move_command_decoder.sv
// Self-checking bench for the incremental move command decoder
`include "imcd_map.vh"
`default_nettype none
module test_incremental_move_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic homeDone = 1'b0;
  logic homeStart, homeToSwitch, homeSwitchHit, hq, homeQ[$];
  logic [1:0] motionPhase = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, moveTarget, q, inc[4];
  logic [31:0] pos = 32'h0;
  logic hreadyout, hresp, enableIn, lineA, lineB;
  logic motorOn, moveStrobe, moveDirCw, moveAltSpeed, moveChain;
  logic [34:0] e, expQ[$];
  int i, j, cyc = 0, n_fail = 0, cmp_count = 0, seed = 32'h142b;
  imcd_decoder i_imcd_decoder (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .enableIn(enableIn), .lineA(lineA), .lineB(lineB), .motionPhase(motionPhase),
    .homeDone(homeDone), .motorOn(motorOn), .moveStrobe(moveStrobe),
    .moveTarget(moveTarget), .moveDirCw(moveDirCw), .moveAltSpeed(moveAltSpeed),
    .moveChain(moveChain), .homeStart(homeStart), .homeToSwitch(homeToSwitch),
    .homeSwitchHit(homeSwitchHit));
  imcd_plc i_imcd_plc (.ref_clk(ref_clk), .enableIn(enableIn), .lineA(lineA),
    .lineB(lineB));
  always #5 ref_clk = ~ref_clk;
  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Case equality so an unknown matches only an unknown in the same bit
  task automatic chk(input string nm, input logic [34:0] x, input logic [34:0] g);
    cmp_count++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One word transfer; address held until hready, read data taken at data end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk("reg", {3'h0, x}, {3'h0, q});
  endtask
  // Note a move: relative to the last target, direction from the sign
  task automatic expMove(input int s, input logic alt, input logic ch);
    pos = pos + inc[s];
    expQ.push_back({ch, alt, inc[s][31], pos});
  endtask
  // Bounded wait for noted moves, then a quiet spell that must stay empty
  task automatic drain();
    for (j = 0; j < 40 && expQ.size() + homeQ.size() > 0; j++) @(posedge ref_clk);
    chk("pending", 35'h0, 35'(expQ.size() + homeQ.size()));
    repeat (10) @(posedge ref_clk);
  endtask
  // Each strobe takes the oldest note; an unnoted strobe meets an unknown
  // Each homing start takes the oldest homing note likewise
  always @(posedge ref_clk)
  begin
    if (moveStrobe === 1'b1)
    begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 'x;
      chk("move", e, {moveChain, moveAltSpeed, moveDirCw, moveTarget});
    end
    if (homeStart === 1'b1)
    begin
      hq = (homeQ.size() > 0) ? homeQ.pop_front() : 1'bx;
      chk("home", {34'h0, hq}, {34'h0, homeToSwitch});
    end
  end
  // Ceiling on the whole run against a hung wait
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`IMCD_OFF_PULSEW, `IMCD_PULSEW_RST);
    rd(`IMCD_OFF_UNIT, 32'h1);
    rd(8'h40, 32'h0);
    bus(1'b1, `IMCD_OFF_PULSEW, 32'h14);
    for (i = 0; i < 4; i++)
    begin
      inc[i] = $random(seed);
      inc[i][31] = i[0];
      bus(1'b1, `IMCD_OFF_INC0 + 8'(4 * i), inc[i]);
      rd(`IMCD_OFF_INC0 + 8'(4 * i), inc[i]);
    end
    i_imcd_plc.dropEnable(1);
    repeat (8) @(posedge ref_clk);
    chk("motor", 35'h1, {34'h0, motorOn});
    // Four-increment selection, line_a the high bit, one move per trigger
    for (i = 0; i < 4; i++)
    begin
      i_imcd_plc.setLines(i[1], i[0]);
      expMove(i, 1'b0, 1'b0);
      i_imcd_plc.dropEnable(6);
      drain();
    end
    // Both lines stay high, so chained and late moves use the fourth increment
    motionPhase <= `IMCD_PH_ACC;
    expMove(3, 1'b0, 1'b1);
    i_imcd_plc.dropEnable(6);
    expMove(3, 1'b0, 1'b1);
    i_imcd_plc.dropEnable(6);
    drain();
    motionPhase <= `IMCD_PH_DEC;
    expMove(3, 1'b0, 1'b0);
    i_imcd_plc.dropEnable(6);
    drain();
    motionPhase <= `IMCD_PH_IDLE;
    i_imcd_plc.dropEnable(40);
    chk("motor", 35'h0, {34'h0, motorOn});
    repeat (10) @(posedge ref_clk);
    // Two-increment hard-stop mode, rising line_a edges launch
    i_imcd_plc.setLines(1'b0, 1'b0);
    bus(1'b1, `IMCD_OFF_CTRL, 32'h11);
    i_imcd_plc.setLines(1'b0, 1'b1);
    expMove(1, 1'b0, 1'b0);
    i_imcd_plc.setLines(1'b1, 1'b1);
    drain();
    i_imcd_plc.dropEnable(6);
    i_imcd_plc.setLines(1'b0, 1'b0);
    drain();
    expMove(0, 1'b1, 1'b0);
    i_imcd_plc.setLines(1'b1, 1'b0);
    drain();
    motionPhase <= `IMCD_PH_ACC;
    for (i = 0; i < 3; i++)
    begin
      i_imcd_plc.setLines(1'b0, 1'b0);
      expMove(0, 1'b0, 1'b1);
      i_imcd_plc.setLines(1'b1, 1'b0);
    end
    drain();
    motionPhase <= `IMCD_PH_IDLE;
    // Single-increment mode on the falling edge
    bus(1'b1, `IMCD_OFF_CTRL, 32'h3);
    expMove(0, 1'b0, 1'b0);
    i_imcd_plc.setLines(1'b0, 1'b0);
    drain();
    // Home-to-switch mode: a decel trigger waits for the stop
    bus(1'b1, `IMCD_OFF_CTRL, 32'h2);
    i_imcd_plc.setLines(1'b1, 1'b0);
    motionPhase <= `IMCD_PH_DEC;
    i_imcd_plc.dropEnable(6);
    repeat (12) @(posedge ref_clk);
    expMove(1, 1'b0, 1'b0);
    motionPhase <= `IMCD_PH_IDLE;
    drain();
    // Switch homing on enable, switch inverted; triggers during homing are ignored
    bus(1'b1, `IMCD_OFF_CTRL, 32'h62);
    repeat (4) @(posedge ref_clk);
    chk("switch", 35'h1, {34'h0, homeSwitchHit});
    homeQ.push_back(1'b1);
    i_imcd_plc.dropEnable(40);
    repeat (8) @(posedge ref_clk);
    i_imcd_plc.dropEnable(6);
    drain();
    homeDone <= 1'b1;
    @(posedge ref_clk);
    homeDone <= 1'b0;
    rd(`IMCD_OFF_STATUS, 32'h5);
    i_imcd_plc.setLines(1'b1, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk("switch", 35'h0, {34'h0, homeSwitchHit});
    // Homing once only: a second enable must not start it
    i_imcd_plc.dropEnable(40);
    repeat (8) @(posedge ref_clk);
    drain();
    // Every enable homes, against the hard stop in the hard-stop mode
    i_imcd_plc.setLines(1'b0, 1'b0);
    bus(1'b1, `IMCD_OFF_CTRL, 32'hd1);
    homeQ.push_back(1'b0);
    i_imcd_plc.dropEnable(40);
    repeat (8) @(posedge ref_clk);
    drain();
    homeDone <= 1'b1;
    @(posedge ref_clk);
    homeDone <= 1'b0;
    // Pulse-burst mode: one unit per line_b pulse, line_a gives the sign
    bus(1'b1, `IMCD_OFF_CTRL, 32'h4);
    inc[0] = ($random(seed) & 32'hffff) | 32'h1;
    inc[1] = 32'h0 - inc[0];
    bus(1'b1, `IMCD_OFF_UNIT, inc[0]);
    rd(`IMCD_OFF_UNIT, inc[0]);
    i_imcd_plc.dropEnable(6);
    for (i = 0; i < 3; i++)
      expMove(0, i == 0, 1'b0);
    i_imcd_plc.burst(1'b0, 3);
    expMove(1, 1'b0, 1'b0);
    expMove(1, 1'b0, 1'b0);
    i_imcd_plc.burst(1'b1, 2);
    drain();
    summarize();
  end
endmodule
`default_nettype wire
